// ### rcod_cfg.svh
// Register map, field positions and reset values of the reference clock output divider
`ifndef RCOD_CFG_SVH
`define RCOD_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define RCOD_CTRL_OFFSET 32'h0000_0000
`define RCOD_STAT_OFFSET 32'h0000_0004

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define RCOD_EN_BIT 15
`define RCOD_SLP_BIT 13
`define RCOD_SRC_BIT 12
`define RCOD_DIV_LSB 8
`define RCOD_DIV_W 4
`define RCOD_CTRL_RESET 16'h0000
`define RCOD_CTRL_WMASK 16'hbf00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define RCOD_STAT_RUN_BIT 0
`define RCOD_STAT_PIN_BIT 1
`define RCOD_STAT_OSCPD_BIT 2
`define RCOD_STAT_HOLD_BIT 3

`endif

// ### rcod_pkg.sv
// Types shared by the reference clock output divider
package rcod_pkg;

   typedef enum logic [2:0] {
      RCOD_ST_OFF = 3'b001,
      RCOD_ST_RUN = 3'b010,
      RCOD_ST_HOLD = 3'b100
   } rcod_state_type;

   typedef enum logic [1:0] {
      RCOD_RESP_OKAY = 2'b00,
      RCOD_RESP_SLVERR = 2'b10
   } rcod_resp_type;

   typedef struct packed {
      logic [31:0] awaddr;
      logic [2:0] awprot;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic [2:0] arprot;
      logic arvalid;
      logic rready;
   } rcod_axil_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      rcod_resp_type bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      rcod_resp_type rresp;
   } rcod_axil_rsp_type;

endpackage

// ### rcod_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none

module rcod_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   if (W < 1) begin : g_bad_width
      $error("rcod_sync: W must be at least 1");
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      logic stage1;
      logic stage2;
      always_ff @(posedge ref_clk_in) begin
         if (rst_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
         end else begin
            stage1 <= async_in[i];
            stage2 <= stage1;
         end
      end
      assign sync_out[i] = stage2;
   end

endmodule // rcod_sync

`default_nettype wire

// ### rcod_divider.sv
// Base clock select and power-of-two divider
`timescale 1ns/1ns
`default_nettype none
`include "rcod_cfg.svh"

module rcod_divider
   import rcod_pkg::*;
#(
   parameter int DIV_W = `RCOD_DIV_W
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Synchronised base clock levels
   input wire logic sys_lvl_in,
   input wire logic pri_lvl_in,
   // Control
   input wire logic src_sel_in,
   input wire logic [DIV_W-1:0] div_sel_in,
   input wire logic run_in,
   // Divided level
   output logic div_level_out
);

   localparam int CNT_W = (1 << DIV_W) - 1;

   if (DIV_W < 1 || DIV_W > `RCOD_DIV_W) begin : g_bad_div
      $error("rcod_divider: DIV_W out of range");
   end

   logic base_lvl;
   logic base_prev;
   logic next_base_prev;
   logic base_rise;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;

   // Counting sampled edges limits each base clock to half of ref_clk_in
   always_comb begin
      base_lvl = src_sel_in ? pri_lvl_in : sys_lvl_in;
      base_rise = base_lvl && !base_prev;
      next_base_prev = base_lvl;
      next_cnt = cnt;
      if (!run_in) begin
         next_cnt = '0;
      end else if (base_rise) begin
         next_cnt = cnt + 1'b1;
      end
      if (div_sel_in == '0) begin
         div_level_out = run_in && base_lvl;
      end else begin
         div_level_out = run_in && cnt[div_sel_in - 1'b1];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         base_prev <= 1'b0;
         cnt <= '0;
      end else begin
         base_prev <= next_base_prev;
         cnt <= next_cnt;
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   cnt_clear_a: assert property (
      !run_in |=> cnt == '0
   ) else $error("divider counter not cleared while stopped");

   cnt_hold_a: assert property (
      run_in && !base_rise |=> $stable(cnt)
   ) else $error("divider counter moved without a base edge");

   half_toggle_a: assert property (
      run_in && div_sel_in == 1 && base_rise ##1 run_in && div_sel_in == 1
         |-> div_level_out != $past(div_level_out)
   ) else $error("divide by two did not toggle on a base edge");

endmodule // rcod_divider

`default_nettype wire

// ### rcod_top.sv
// Reference clock output divider: register slave, run control and pin drive
`timescale 1ns/1ns
`default_nettype none
`include "rcod_cfg.svh"

// Notes on behaviour
// - Enable bit drives divided clock onto pin
// - Divide base clock by two to field
// - Source bit picks primary oscillator or system
// - Sleep-run bit keeps output alive in Sleep
// - Sleep output needs sleep-run and primary source
// - Sleep powers primary down unless kept
// - Output available in every oscillator configuration
// - Unimplemented bits read zero, writes ignored
module rcod_top
   import rcod_pkg::*;
#(
   parameter int DIV_W = `RCOD_DIV_W
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Register bus
   input wire rcod_axil_req_type axil_req_in,
   output var rcod_axil_rsp_type axil_rsp_out,
   // Base clocks from outside the domain
   input wire logic sys_clk_in,
   input wire logic pri_osc_in,
   // Power state and oscillator configuration
   input wire logic sleep_in,
   input wire logic pri_osc_primary_mode_in,
   input wire logic primary_osc_keep_in_sleep_in,
   // Pin and oscillator control
   output logic ref_clock_pin_out,
   output logic ref_clock_pin_oe_n_out,
   output logic pri_osc_power_down_out
);

   if (DIV_W != `RCOD_DIV_W) begin : g_bad_div
      $error("rcod_top: DIV_W must match the divisor field width");
   end

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   rcod_axil_rsp_type rsp_q;
   rcod_axil_rsp_type next_rsp;
   logic aw_held;
   logic next_aw_held;
   logic [31:0] awaddr_q;
   logic [31:0] next_awaddr;
   logic w_held;
   logic next_w_held;
   logic [31:0] wdata_q;
   logic [31:0] next_wdata;
   logic [3:0] wstrb_q;
   logic [3:0] next_wstrb;
   logic wr_is_ctrl;
   logic wr_is_stat;
   logic ctrl_wr;
   logic [31:0] rd_data;
   logic rd_err;

   logic [15:0] ctrl_q;
   logic [15:0] next_ctrl;
   logic ctrl_en;
   logic ctrl_slp;
   logic ctrl_src;
   logic [DIV_W-1:0] ctrl_div;

   rcod_state_type state;
   rcod_state_type next_state;
   logic osc_keeps;
   logic sleep_ok;
   logic next_pin;
   logic next_oe_n;
   logic next_osc_pd;

   logic [1:0] clk_sync;
   logic div_level;

   // ----------------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------------
   assign wr_is_ctrl = {awaddr_q[31:2], 2'b00} == `RCOD_CTRL_OFFSET;
   assign wr_is_stat = {awaddr_q[31:2], 2'b00} == `RCOD_STAT_OFFSET;

   // Read mux looks at the live araddr input; the master keeps it stable while arvalid
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      case ({axil_req_in.araddr[31:2], 2'b00})
         `RCOD_CTRL_OFFSET: begin
            rd_data = {16'h0000, ctrl_q & `RCOD_CTRL_WMASK};
         end
         `RCOD_STAT_OFFSET: begin
            rd_data[`RCOD_STAT_RUN_BIT] = state == RCOD_ST_RUN;
            rd_data[`RCOD_STAT_PIN_BIT] = ref_clock_pin_out;
            rd_data[`RCOD_STAT_OSCPD_BIT] = pri_osc_power_down_out;
            rd_data[`RCOD_STAT_HOLD_BIT] = state == RCOD_ST_HOLD;
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   always_comb begin
      next_rsp = rsp_q;
      next_aw_held = aw_held;
      next_awaddr = awaddr_q;
      next_w_held = w_held;
      next_wdata = wdata_q;
      next_wstrb = wstrb_q;
      ctrl_wr = 1'b0;
      if (axil_req_in.awvalid && rsp_q.awready) begin
         next_aw_held = 1'b1;
         next_awaddr = axil_req_in.awaddr;
      end
      if (axil_req_in.wvalid && rsp_q.wready) begin
         next_w_held = 1'b1;
         next_wdata = axil_req_in.wdata;
         next_wstrb = axil_req_in.wstrb;
      end
      // Address and data may arrive in either order; commit once both are held
      if (aw_held && w_held && !rsp_q.bvalid) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_rsp.bvalid = 1'b1;
         next_rsp.bresp = (wr_is_ctrl || wr_is_stat) ? RCOD_RESP_OKAY : RCOD_RESP_SLVERR;
         ctrl_wr = wr_is_ctrl;
      end
      if (rsp_q.bvalid && axil_req_in.bready) begin
         next_rsp.bvalid = 1'b0;
      end
      if (axil_req_in.arvalid && rsp_q.arready) begin
         next_rsp.rvalid = 1'b1;
         next_rsp.rdata = rd_data;
         next_rsp.rresp = rd_err ? RCOD_RESP_SLVERR : RCOD_RESP_OKAY;
      end
      if (rsp_q.rvalid && axil_req_in.rready) begin
         next_rsp.rvalid = 1'b0;
      end
      // Ready signals are registered so every bus output leaves a flip-flop
      next_rsp.awready = !next_aw_held && !next_rsp.bvalid;
      next_rsp.wready = !next_w_held && !next_rsp.bvalid;
      next_rsp.arready = !next_rsp.rvalid;
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rsp_q <= '0;
         aw_held <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         w_held <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         rsp_q <= next_rsp;
         aw_held <= next_aw_held;
         awaddr_q <= next_awaddr;
         w_held <= next_w_held;
         wdata_q <= next_wdata;
         wstrb_q <= next_wstrb;
      end
   end

   assign axil_rsp_out = rsp_q;

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl_q;
      if (ctrl_wr) begin
         if (wstrb_q[1]) begin
            next_ctrl[15:8] = wdata_q[15:8];
         end
         if (wstrb_q[0]) begin
            next_ctrl[7:0] = wdata_q[7:0];
         end
      end
      next_ctrl = next_ctrl & `RCOD_CTRL_WMASK;
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ctrl_q <= `RCOD_CTRL_RESET;
      end else begin
         ctrl_q <= next_ctrl;
      end
   end

   assign ctrl_en = ctrl_q[`RCOD_EN_BIT];
   assign ctrl_slp = ctrl_q[`RCOD_SLP_BIT];
   assign ctrl_src = ctrl_q[`RCOD_SRC_BIT];
   assign ctrl_div = ctrl_q[`RCOD_DIV_LSB +: DIV_W];

   // ----------------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------------
   // No gating on the system clock mode: any configuration may use the output
   always_comb begin
      osc_keeps = pri_osc_primary_mode_in || primary_osc_keep_in_sleep_in;
      sleep_ok = ctrl_slp && ctrl_src && osc_keeps;
      next_osc_pd = sleep_in && !osc_keeps;
      next_state = state;
      case (state)
         RCOD_ST_OFF: begin
            if (ctrl_en) begin
               next_state = (sleep_in && !sleep_ok) ? RCOD_ST_HOLD : RCOD_ST_RUN;
            end
         end
         RCOD_ST_RUN: begin
            if (!ctrl_en) begin
               next_state = RCOD_ST_OFF;
            end else if (sleep_in && !sleep_ok) begin
               next_state = RCOD_ST_HOLD;
            end
         end
         RCOD_ST_HOLD: begin
            if (!ctrl_en) begin
               next_state = RCOD_ST_OFF;
            end else if (!sleep_in || sleep_ok) begin
               next_state = RCOD_ST_RUN;
            end
         end
         default: begin
            next_state = RCOD_ST_OFF;
         end
      endcase
      // Held low while stopped in Sleep, released only when disabled
      next_pin = (state == RCOD_ST_RUN) && div_level;
      next_oe_n = state == RCOD_ST_OFF;
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= RCOD_ST_OFF;
         ref_clock_pin_out <= 1'b0;
         ref_clock_pin_oe_n_out <= 1'b1;
         pri_osc_power_down_out <= 1'b0;
      end else begin
         state <= next_state;
         ref_clock_pin_out <= next_pin;
         ref_clock_pin_oe_n_out <= next_oe_n;
         pri_osc_power_down_out <= next_osc_pd;
      end
   end

   // ----------------------------------------------------------------------
   // Base clock sampling and division
   // ----------------------------------------------------------------------
   rcod_sync #(
      .W(2)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .async_in({pri_osc_in, sys_clk_in}),
      .sync_out(clk_sync)
   );

   rcod_divider #(
      .DIV_W(DIV_W)
   ) u_divider (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .sys_lvl_in(clk_sync[0]),
      .pri_lvl_in(clk_sync[1]),
      .src_sel_in(ctrl_src),
      .div_sel_in(ctrl_div),
      .run_in(state == RCOD_ST_RUN),
      .div_level_out(div_level)
   );

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   pin_disable_a: assert property (
      !ctrl_en |-> ##2 (!ref_clock_pin_out && ref_clock_pin_oe_n_out)
   ) else $error("pin not released low after disable");

   pin_enable_a: assert property (
      ctrl_en && !sleep_in ##1 ctrl_en && !sleep_in |-> ##1 !ref_clock_pin_oe_n_out
   ) else $error("pin not driven while enabled");

   sleep_stop_a: assert property (
      sleep_in && !(ctrl_slp && ctrl_src && osc_keeps) |-> ##2 !ref_clock_pin_out
   ) else $error("pin toggled in Sleep without permission");

   // Sleep and source are judged at the edge that picks the next state, so a wake one cycle later is legal
   sleep_run_a: assert property (
      ctrl_en && sleep_in && !ctrl_src |=> state != RCOD_ST_RUN
   ) else $error("output running in Sleep from the system clock");

   osc_power_a: assert property (
      sleep_in && !pri_osc_primary_mode_in && !primary_osc_keep_in_sleep_in
         |=> pri_osc_power_down_out
   ) else $error("primary oscillator not powered down in Sleep");

   osc_awake_a: assert property (
      !sleep_in |=> !pri_osc_power_down_out
   ) else $error("primary oscillator powered down while awake");

   rsvd_zero_a: assert property (
      (ctrl_q & ~`RCOD_CTRL_WMASK) == 16'h0000
   ) else $error("unimplemented control bits hold a one");

   wr_resp_a: assert property (
      axil_req_in.awvalid && rsp_q.awready && axil_req_in.wvalid && rsp_q.wready
         |-> ##2 rsp_q.bvalid
   ) else $error("write response not given two cycles after request");

   bresp_hold_a: assert property (
      rsp_q.bvalid && !axil_req_in.bready |=> rsp_q.bvalid && $stable(rsp_q.bresp)
   ) else $error("write response dropped before bready");

   rdata_hold_a: assert property (
      rsp_q.rvalid && !axil_req_in.rready |=> rsp_q.rvalid && $stable(rsp_q.rdata)
   ) else $error("read data changed before rready");

   unmapped_rd_a: assert property (
      axil_req_in.arvalid && rsp_q.arready && rd_err
         |=> rsp_q.rvalid && rsp_q.rresp == RCOD_RESP_SLVERR && rsp_q.rdata == 32'h0000_0000
   ) else $error("unmapped read not answered with an error");

   run_slowest_c: cover property (state == RCOD_ST_RUN && ctrl_div == 4'hf && ref_clock_pin_out);
   sleep_hold_c: cover property (state == RCOD_ST_HOLD ##1 state == RCOD_ST_RUN);
   sleep_run_c: cover property (sleep_in && state == RCOD_ST_RUN && ref_clock_pin_out);
   bad_write_c: cover property (rsp_q.bvalid && rsp_q.bresp == RCOD_RESP_SLVERR);

endmodule // rcod_top

`default_nettype wire

// ### rcod_clk_monitor.sv
// External device watching the reference clock pin: samples it on ref_clk_in, counts and times rising edges
`timescale 1ns/1ns
`default_nettype none

module rcod_clk_monitor (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Board line seen by the external device
   input wire logic line_in,
   // Measurements
   output logic [31:0] rise_cnt_out,
   output logic [31:0] period_out
);
   logic prev;
   logic [31:0] gap;

   // Period is the count of sampling cycles from one rising edge to the next
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         prev <= 1'b0;
         gap <= 32'h0;
         rise_cnt_out <= 32'h0;
         period_out <= 32'h0;
      end else begin
         prev <= line_in;
         gap <= gap + 32'h1;
         if (line_in && !prev) begin
            rise_cnt_out <= rise_cnt_out + 32'h1;
            period_out <= gap + 32'h1;
            gap <= 32'h0;
         end
      end
   end
endmodule // rcod_clk_monitor

`default_nettype wire

// ### rcod_top_tb.sv
// Self-checking testbench of the reference clock output divider
`timescale 1ns/1ns
`default_nettype none
`include "rcod_cfg.svh"

module rcod_top_tb
   import rcod_pkg::*;
;
   logic ref_clk_in, rst_in, sys_clk, pri_osc, sleep, mode, keep, pin, oe_n, pdn;
   logic [2:0] sc, pc;
   logic [1:0] r;
   logic [31:0] d, rd, c0, rise_cnt, period;
   int seed, n_fail, checks, i, k, n;
   logic src, slp, hi;
   rcod_axil_req_type req;
   rcod_axil_rsp_type rsp;
   wire logic line_lvl;

   // Board pull-down holds the line low while the pin is released
   assign line_lvl = oe_n ? 1'b0 : pin;

   rcod_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .axil_req_in(req), .axil_rsp_out(rsp),
      .sys_clk_in(sys_clk), .pri_osc_in(pri_osc), .sleep_in(sleep), .pri_osc_primary_mode_in(mode),
      .primary_osc_keep_in_sleep_in(keep), .ref_clock_pin_out(pin), .ref_clock_pin_oe_n_out(oe_n),
      .pri_osc_power_down_out(pdn));

   rcod_clk_monitor mon (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .line_in(line_lvl),
      .rise_cnt_out(rise_cnt), .period_out(period));

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // ----------------------------------------------------------------------
   // Base clocks: system period 8 cycles, primary period 10 cycles
   // ----------------------------------------------------------------------
   // A powered-down oscillator stops, so the primary clock freezes then
   always @(posedge ref_clk_in) begin
      sc <= (sc == 3'd3) ? 3'd0 : sc + 3'd1;
      if (sc == 3'd3) sys_clk <= ~sys_clk;
      if (!pdn) begin
         pc <= (pc == 3'd4) ? 3'd0 : pc + 3'd1;
         if (pc == 3'd4) pri_osc <= ~pri_osc;
      end
   end

   function automatic logic [31:0] exp_period(input logic s, input int code);
      return (s ? 32'd10 : 32'd8) << code;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic axi_write(input logic [31:0] a, input logic [31:0] dat, output logic [1:0] resp);
      int t;
      @(posedge ref_clk_in);
      req.awaddr <= a;
      req.wdata <= dat;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      t = 0;
      do begin
         @(posedge ref_clk_in);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         t++;
      end while (rsp.bvalid !== 1'b1 && t < 50);
      resp = rsp.bresp;
      req.bready <= 1'b0;
      if (t >= 50) check("write timeout", 32'h1, 32'h0);
   endtask

   task automatic axi_read(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] resp);
      int t;
      @(posedge ref_clk_in);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      t = 0;
      do begin
         @(posedge ref_clk_in);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         t++;
      end while (rsp.rvalid !== 1'b1 && t < 50);
      dat = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
      if (t >= 50) check("read timeout", 32'h1, 32'h0);
   endtask

   task automatic wait_rises(input int cnt, input int limit);
      logic [31:0] base;
      int t;
      base = rise_cnt;
      t = 0;
      while (rise_cnt < base + cnt && t < limit) begin
         @(posedge ref_clk_in);
         t++;
      end
      if (t >= limit) check("rise timeout", 32'h1, 32'h0);
   endtask

   task automatic final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run needs well under 60k cycles
   initial begin
      #1200000;
      n_fail++;
      final_report;
   end

   initial begin
      seed = 32'h0241;
      n_fail = 0;
      checks = 0;
      req = '0;
      rst_in = 1'b1;
      sys_clk = 1'b0;
      pri_osc = 1'b0;
      sc = 3'd0;
      pc = 3'd0;
      sleep = 1'b0;
      mode = 1'b0;
      keep = 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      // ----------------------------------------------------------------------
      // Reset state and register access
      // ----------------------------------------------------------------------
      check("pin", pin, 32'h0);
      check("oe_n", oe_n, 32'h1);
      check("pdn", pdn, 32'h0);
      axi_read(`RCOD_CTRL_OFFSET, rd, r);
      check("ctrl reset", rd, 32'h0);
      axi_write(`RCOD_CTRL_OFFSET, 32'hffff_ffff, r);
      check("bresp", r, 32'h0);
      // Status is read-only: the write is answered OKAY and changes nothing
      axi_write(`RCOD_STAT_OFFSET, 32'hffff_ffff, r);
      check("stat bresp", r, 32'h0);
      axi_read(`RCOD_CTRL_OFFSET, rd, r);
      check("ctrl mask", rd, 32'h0000_bf00);
      axi_write(32'h0000_0010, 32'h0000_8000, r);
      check("unmapped bresp", r, 32'h2);
      axi_read(32'h0000_0010, rd, r);
      check("unmapped rresp", r, 32'h2);
      check("unmapped rdata", rd, 32'h0);
      $display("test registers done");
      // ----------------------------------------------------------------------
      // Divisor and source sweep, oscillator configuration random
      // ----------------------------------------------------------------------
      for (i = 0; i < 14; i++) begin
         src = i[0];
         d = $random(seed);
         n = (i < 12) ? i / 2 : d[18:16] % 6;
         {mode, keep} <= d[21:20];
         d[15] = 1'b1;
         d[12] = src;
         d[11:8] = n[3:0];
         axi_write(`RCOD_CTRL_OFFSET, d, r);
         axi_read(`RCOD_CTRL_OFFSET, rd, r);
         check("ctrl readback", rd, d & 32'h0000_bf00);
         wait_rises(3, 2000);
         check("period", period, exp_period(src, n));
         check("oe_n on", oe_n, 32'h0);
      end
      $display("test divisor done");
      // ----------------------------------------------------------------------
      // Disable, clean restart, largest divisor
      // ----------------------------------------------------------------------
      axi_write(`RCOD_CTRL_OFFSET, 32'h0, r);
      repeat (4) @(posedge ref_clk_in);
      check("oe_n off", oe_n, 32'h1);
      check("pin off", pin, 32'h0);
      axi_read(`RCOD_STAT_OFFSET, rd, r);
      check("status off", rd, 32'h0);
      repeat (30) @(posedge ref_clk_in);
      axi_write(`RCOD_CTRL_OFFSET, 32'h0000_8400, r);
      hi = 1'b0;
      // Cleared counter keeps the pin low for 8 base edges, at least 56 cycles
      repeat (50) begin
         @(posedge ref_clk_in);
         hi = hi | pin;
      end
      check("restart low", hi, 32'h0);
      axi_write(`RCOD_CTRL_OFFSET, 32'h0000_8f00, r);
      c0 = rise_cnt;
      repeat (2000) @(posedge ref_clk_in);
      check("code 15 edges", rise_cnt - c0, 32'h0);
      $display("test restart done");
      // ----------------------------------------------------------------------
      // Sleep behaviour over every combination of the four controls
      // ----------------------------------------------------------------------
      for (i = 0; i < 16; i++) begin
         {slp, src} = i[3:2];
         {mode, keep} <= i[1:0];
         d = 32'h0000_8100 | ({31'h0, slp} << 13) | ({31'h0, src} << 12);
         axi_write(`RCOD_CTRL_OFFSET, d, r);
         repeat (40) @(posedge ref_clk_in);
         sleep <= 1'b1;
         repeat (3) @(posedge ref_clk_in);
         check("pdn", pdn, {31'h0, !(i[1] | i[0])});
         c0 = rise_cnt;
         repeat (100) @(posedge ref_clk_in);
         hi = slp & src & (i[1] | i[0]);
         check("sleep run", rise_cnt != c0, {31'h0, hi});
         if (!hi) check("sleep pin", pin, 32'h0);
         check("sleep oe_n", oe_n, 32'h0);
         // Pin level bit is left out: it toggles while running
         axi_read(`RCOD_STAT_OFFSET, rd, r);
         check("status", rd & 32'h0000_000d, {28'h0, !hi, !(i[1] | i[0]), 1'b0, hi});
         sleep <= 1'b0;
         repeat (5) @(posedge ref_clk_in);
      end
      $display("test sleep done");
      final_report;
   end
endmodule // rcod_top_tb

`default_nettype wire
